// file: include/swrc_pkg.sv
package swrc_pkg;
	// Core clock
	localparam int unsigned CLK_PERIOD_NS      = 10;
	// Oscillator restart after a wake, before the reset hold starts
	localparam int unsigned OSC_START_NS       = 200;
	localparam int unsigned OSC_START_CYCLES   =
		(OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Minimum device reset pulse
	localparam int unsigned RESET_HOLD_NS      = 100;
	localparam int unsigned RESET_HOLD_CYCLES  =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Watchdog period
	localparam int unsigned WDT_TIMEOUT_NS     = 18000000;
	localparam int unsigned WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_NS / CLK_PERIOD_NS;

	// Widths
	localparam int unsigned ADDR_W             = 4;
	localparam int unsigned DATA_W             = 32;
	localparam int unsigned BE_W               = 4;
	localparam int unsigned PORT_W             = 6;
	localparam int unsigned WAKE_W             = 3;
	localparam int unsigned HOLD_W             = 8;
	localparam int unsigned WDT_W              = 24;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL  = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_WAKE_REF = 4'h8;

	// Status fields
	localparam int unsigned STAT_PIN_WAKE_BIT  = 7;
	localparam int unsigned STAT_TIMEOUT_BIT   = 4;
	localparam int unsigned STAT_POWERDOWN_BIT = 3;
	localparam int unsigned STAT_ASLEEP_BIT    = 0;

	// Control fields
	localparam int unsigned CTRL_WDT_EN_BIT    = 0;
	localparam int unsigned CTRL_WAKE_CHG_BIT  = 1;
	localparam int unsigned CTRL_RST_PIN_BIT   = 2;
	localparam int unsigned CTRL_W             = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET    = 3'h5;

	// Flag values at power-up
	localparam logic PIN_WAKE_POR  = 1'b0;
	localparam logic TIMEOUT_POR   = 1'b1;
	localparam logic POWERDOWN_POR = 1'b1;

	// Hold counter reload values
	localparam logic [HOLD_W-1:0] OSC_START_LOAD  = HOLD_W'(OSC_START_CYCLES);
	localparam logic [HOLD_W-1:0] RESET_HOLD_LOAD = HOLD_W'(RESET_HOLD_CYCLES);

	typedef enum logic [1:0] {
		st_run,
		st_sleep,
		st_restart,
		st_reset
	} swrc_state_e;
endpackage : swrc_pkg

// file: hw/swrc_sync3.sv
`timescale 1ns/100ps
module swrc_sync3 #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] agree;

	// Bit counts only when stages two and three match
	assign agree = ~(stage2_reg ^ stage3_reg);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage1_reg <= INIT;
			stage2_reg <= INIT;
			stage3_reg <= INIT;
			out_reg    <= INIT;
		end else if (clk_en) begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			out_reg    <= (stage2_reg & agree) | (out_reg & ~agree);
		end
	end

	assign sync_out = out_reg;
endmodule : swrc_sync3

// file: hw/swrc_watchdog.sv
`timescale 1ns/100ps
module swrc_watchdog #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned LIMIT = 1800000
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic enable,
	input  wire logic clear,
	output logic      expired
);
	localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

	logic [WIDTH-1:0] count_reg;
	logic             expired_reg;
	logic             at_last;

	assign at_last = (count_reg == LAST);

	// Counter restarts on clear, expiry or disable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_reg   <= '0;
			expired_reg <= 1'b0;
		end else if (clk_en) begin
			expired_reg <= enable & ~clear & at_last;
			if (clear || !enable || at_last) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	assign expired = expired_reg;
endmodule : swrc_watchdog

// file: hw/swrc_sleep_wake.sv
`timescale 1ns/100ps
// Functional notes
// - Watchdog wake from sleep clears all three flags
// - Watchdog reset awake: clear pin-wake, timeout; keep powerdown
// - Reset-pin wake: pin-wake 0, timeout 1, powerdown 0
// - Power-up: pin-wake 0, timeout 1, powerdown 1
// - Reset-pin reset awake: clear pin-wake only
// - Pin-change wake: pin-wake 1, timeout 1, powerdown 0
// - Flags hold until a reset event or sleep entry
// - Reset-pin pulse changes flags only per encoding
// - Sleep: clear watchdog, timeout 1, powerdown 0, oscillator off
// - Pads keep their drive state during sleep
// - Watchdog reset never drives the reset pin
// - Wake on reset pin, watchdog or pin change
// - Every wake gives a device reset with cause
// - Pin-wake means wake pins changed in sleep
// - Compare against last port read; stale mismatch rewakes
// - Watchdog cleared on every wake
module swrc_sleep_wake
	import swrc_pkg::*;
#(
	parameter int unsigned WDT_LIMIT = swrc_pkg::WDT_TIMEOUT_CYCLES
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	input  wire logic [swrc_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [swrc_pkg::BE_W-1:0]   avs_byteenable,
	input  wire logic [swrc_pkg::DATA_W-1:0] avs_writedata,
	output logic      [swrc_pkg::DATA_W-1:0] avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        sleep_exec,
	input  wire logic                        port_access,
	input  wire logic                        wdt_clear,
	input  wire logic                        wake_pin_a,
	input  wire logic                        wake_pin_b,
	input  wire logic                        shared_reset_program_pin,
	input  wire logic [swrc_pkg::PORT_W-1:0] core_pad_out,
	input  wire logic [swrc_pkg::PORT_W-1:0] core_pad_oe,
	output logic      [swrc_pkg::PORT_W-1:0] pad_out,
	output logic      [swrc_pkg::PORT_W-1:0] pad_oe,
	output logic                             device_reset,
	output logic                             osc_drive_en,
	output logic                             asleep,
	output logic                             timeout_flag_n,
	output logic                             powerdown_flag_n,
	output logic                             pin_wake_flag
);
	import swrc_pkg::*;

	swrc_state_e         state_reg;
	swrc_state_e         state_next;
	logic [HOLD_W-1:0]   hold_reg;
	logic [HOLD_W-1:0]   hold_next;
	logic [CTRL_W-1:0]   ctrl_reg;
	logic [WAKE_W-1:0]   wake_ref_reg;
	logic                pin_wake_reg;
	logic                timeout_n_reg;
	logic                powerdown_n_reg;
	logic                waitreq_reg;
	logic [DATA_W-1:0]   rdata_reg;
	logic [PORT_W-1:0]   pad_out_reg;
	logic [PORT_W-1:0]   pad_oe_reg;
	logic                dev_reset_reg;
	logic                osc_en_reg;
	logic                asleep_reg;

	logic [WAKE_W-1:0]   pins_raw;
	logic [WAKE_W-1:0]   pins_sync;
	logic                wake_pin_a_s;
	logic                wake_pin_b_s;
	logic                wake_pin_c;
	logic                external_reset_pin_n;
	logic                wdt_en;
	logic                wake_chg_en;
	logic                rst_pin_en;
	logic                wdt_expired;
	logic                wdt_clr;
	logic [WAKE_W-1:0]   chg_mask;
	logic                pin_changed;

	logic                in_run;
	logic                in_sleep;
	logic                ext_rst_evt;
	logic                wdt_evt;
	logic                chg_evt;
	logic                sleep_evt;
	logic                run_rst_evt;
	logic                wake_evt;
	logic                flag_load;
	logic                pin_wake_next;
	logic                timeout_n_next;
	logic                powerdown_n_next;

	logic                bus_req;
	logic                bus_take;
	logic                bus_wr;
	logic                sel_status;
	logic                sel_control;
	logic                sel_wake_ref;
	logic [DATA_W-1:0]   status_word;
	logic [DATA_W-1:0]   control_word;
	logic [DATA_W-1:0]   wake_ref_word;
	logic [DATA_W-1:0]   read_word;

	// Pin synchronisers
	assign pins_raw = {shared_reset_program_pin, wake_pin_b, wake_pin_a};

	swrc_sync3 #(
		.WIDTH (WAKE_W),
		.INIT  ({WAKE_W{1'b1}})
	) u_pin_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	assign wake_pin_a_s = pins_sync[0];
	assign wake_pin_b_s = pins_sync[1];
	assign wake_pin_c   = pins_sync[2];

	// Control fields
	assign wdt_en      = ctrl_reg[CTRL_WDT_EN_BIT];
	assign wake_chg_en = ctrl_reg[CTRL_WAKE_CHG_BIT];
	assign rst_pin_en  = ctrl_reg[CTRL_RST_PIN_BIT];

	// Shared pin acts as reset input only when configured so
	assign external_reset_pin_n = wake_pin_c | ~rst_pin_en;

	// Watchdog, cleared on sleep, on wake and by the core
	assign wdt_clr = wdt_clear | sleep_evt | wake_evt | run_rst_evt;

	swrc_watchdog #(
		.WIDTH (WDT_W),
		.LIMIT (WDT_LIMIT)
	) u_watchdog (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.enable   (wdt_en & (in_run | in_sleep)),
		.clear    (wdt_clr),
		.expired  (wdt_expired)
	);

	// Pin change against last port read; reset pin excluded when in use
	assign chg_mask    = {~rst_pin_en, 1'b1, 1'b1};
	assign pin_changed = |(({wake_pin_c, wake_pin_b_s, wake_pin_a_s} ^ wake_ref_reg)
		& chg_mask);

	// Event decode, reset pin first, then watchdog, then pin change
	assign in_run      = (state_reg == st_run);
	assign in_sleep    = (state_reg == st_sleep);
	assign ext_rst_evt = ~external_reset_pin_n & (in_run | in_sleep);
	assign wdt_evt     = wdt_expired & ~ext_rst_evt & (in_run | in_sleep);
	assign chg_evt     = in_sleep & wake_chg_en & pin_changed & ~ext_rst_evt & ~wdt_evt;
	assign sleep_evt   = in_run & sleep_exec & ~ext_rst_evt & ~wdt_evt;
	assign run_rst_evt = in_run & (ext_rst_evt | wdt_evt);
	assign wake_evt    = in_sleep & (ext_rst_evt | wdt_evt | chg_evt);

	// Flag encoding per cause
	assign flag_load = sleep_evt | run_rst_evt | wake_evt;

	assign pin_wake_next = chg_evt ? 1'b1 :
		sleep_evt ? pin_wake_reg : 1'b0;

	assign timeout_n_next = wdt_evt ? 1'b0 :
		(in_run & ext_rst_evt) ? timeout_n_reg : 1'b1;

	assign powerdown_n_next = in_sleep ? 1'b0 :
		sleep_evt ? 1'b0 : powerdown_n_reg;

	// Sequencer
	always_comb begin
		state_next = state_reg;
		hold_next  = hold_reg;
		unique case (state_reg)
			st_run: begin
				if (run_rst_evt) begin
					state_next = st_reset;
					hold_next  = RESET_HOLD_LOAD;
				end else if (sleep_evt) begin
					state_next = st_sleep;
				end
			end
			st_sleep: begin
				// Wake restarts the oscillator before the reset is released
				if (wake_evt) begin
					state_next = st_restart;
					hold_next  = OSC_START_LOAD;
				end
			end
			st_restart: begin
				if (hold_reg == '0) begin
					state_next = st_reset;
					hold_next  = RESET_HOLD_LOAD;
				end else begin
					hold_next = hold_reg - 1'b1;
				end
			end
			st_reset: begin
				// Held while the reset pin stays low
				if (!external_reset_pin_n) begin
					hold_next = RESET_HOLD_LOAD;
				end else if (hold_reg == '0) begin
					state_next = st_run;
				end else begin
					hold_next = hold_reg - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= st_reset;
			hold_reg  <= RESET_HOLD_LOAD;
		end else if (clk_en) begin
			state_reg <= state_next;
			hold_reg  <= hold_next;
		end
	end

	// Reset-cause flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_wake_reg    <= PIN_WAKE_POR;
			timeout_n_reg   <= TIMEOUT_POR;
			powerdown_n_reg <= POWERDOWN_POR;
		end else if (clk_en && flag_load) begin
			pin_wake_reg    <= pin_wake_next;
			timeout_n_reg   <= timeout_n_next;
			powerdown_n_reg <= powerdown_n_next;
		end
	end

	// Reference levels for pin-change wake
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_ref_reg <= {WAKE_W{1'b1}};
		end else if (clk_en && in_run && port_access) begin
			wake_ref_reg <= pins_sync;
		end
	end

	// Pads follow the core while running and freeze in sleep
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pad_out_reg <= '0;
			pad_oe_reg  <= '0;
		end else if (clk_en && in_run && !sleep_evt) begin
			pad_out_reg <= core_pad_out;
			pad_oe_reg  <= core_pad_oe;
		end
	end

	// Oscillator driver, sleep marker and device reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_en_reg    <= 1'b1;
			asleep_reg    <= 1'b0;
			dev_reset_reg <= 1'b1;
		end else if (clk_en) begin
			osc_en_reg    <= (state_next != st_sleep);
			asleep_reg    <= (state_next == st_sleep);
			dev_reset_reg <= (state_next == st_reset) || (state_next == st_restart);
		end
	end

	// Avalon slave decode
	assign bus_req      = avs_read | avs_write;
	assign bus_take     = bus_req & waitreq_reg;
	assign bus_wr       = avs_write & ~waitreq_reg;
	assign sel_status   = (avs_address == ADDR_STATUS);
	assign sel_control  = (avs_address == ADDR_CONTROL);
	assign sel_wake_ref = (avs_address == ADDR_WAKE_REF);

	assign status_word = (DATA_W'(pin_wake_reg) << STAT_PIN_WAKE_BIT)
		| (DATA_W'(timeout_n_reg) << STAT_TIMEOUT_BIT)
		| (DATA_W'(powerdown_n_reg) << STAT_POWERDOWN_BIT)
		| (DATA_W'(asleep_reg) << STAT_ASLEEP_BIT);
	assign control_word  = DATA_W'(ctrl_reg);
	assign wake_ref_word = DATA_W'(wake_ref_reg);

	assign read_word = sel_status   ? status_word :
		sel_control  ? control_word :
		sel_wake_ref ? wake_ref_word : '0;

	// One wait cycle, then a single-cycle answer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			waitreq_reg <= 1'b1;
			rdata_reg   <= '0;
		end else if (clk_en) begin
			waitreq_reg <= ~bus_take;
			if (bus_take && avs_read) begin
				rdata_reg <= read_word;
			end
		end
	end

	// Control register, low byte lane
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
		end else if (clk_en && bus_wr && sel_control && avs_byteenable[0]) begin
			ctrl_reg <= avs_writedata[CTRL_W-1:0];
		end
	end

	// No output ever drives the reset pin; it is sensed only
	assign avs_readdata     = rdata_reg;
	assign avs_waitrequest  = waitreq_reg;
	assign pad_out          = pad_out_reg;
	assign pad_oe           = pad_oe_reg;
	assign device_reset     = dev_reset_reg;
	assign osc_drive_en     = osc_en_reg;
	assign asleep           = asleep_reg;
	assign timeout_flag_n   = timeout_n_reg;
	assign powerdown_flag_n = powerdown_n_reg;
	assign pin_wake_flag    = pin_wake_reg;
endmodule : swrc_sleep_wake

// file: tb/swrc_sleep_wake_checker.sv
`timescale 1ns/100ps
module swrc_sleep_wake_checker (
	input wire logic                        core_clk,
	input wire logic                        rst,
	input wire logic                        clk_en,
	input wire logic                        avs_read,
	input wire logic                        avs_write,
	input wire logic                        avs_waitrequest,
	input wire logic                        sleep_exec,
	input wire logic [swrc_pkg::PORT_W-1:0] pad_out,
	input wire logic [swrc_pkg::PORT_W-1:0] pad_oe,
	input wire logic                        device_reset,
	input wire logic                        osc_drive_en,
	input wire logic                        asleep,
	input wire logic                        timeout_flag_n,
	input wire logic                        powerdown_flag_n,
	input wire logic                        pin_wake_flag
);
	import swrc_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_sleep_entry;
		sleep_exec && clk_en && !asleep && !device_reset
			|=> asleep && !osc_drive_en && timeout_flag_n && !powerdown_flag_n;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
	property p_pd_fall;
		$fell(powerdown_flag_n) |-> asleep && timeout_flag_n;
	endproperty
	a_pd_fall: assert property (p_pd_fall) else $error("powerdown cleared awake");
	property p_osc_off;
		asleep |-> !osc_drive_en;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator on in sleep");
	property p_pads_hold;
		asleep && $past(asleep) |-> $stable(pad_out) && $stable(pad_oe);
	endproperty
	a_pads_hold: assert property (p_pads_hold) else $error("pads moved in sleep");
	property p_pin_wake;
		$rose(pin_wake_flag) |-> $past(asleep) && timeout_flag_n && !powerdown_flag_n
			&& device_reset;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("pin wake flags wrong");
	property p_to_fall;
		$fell(timeout_flag_n) |-> !pin_wake_flag ##[0:1] device_reset;
	endproperty
	a_to_fall: assert property (p_to_fall) else $error("timeout flags wrong");
	property p_wake_hold;
		$fell(asleep) |-> device_reset [*8];
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake reset too short");
	property p_flags_hold;
		!$stable({timeout_flag_n, powerdown_flag_n, pin_wake_flag}) |-> device_reset || asleep;
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags changed");
	property p_release;
		$fell(device_reset) |-> osc_drive_en && !asleep;
	endproperty
	a_release: assert property (p_release) else $error("reset released early");
	property p_bus;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule : swrc_sleep_wake_checker

bind swrc_sleep_wake swrc_sleep_wake_checker swrc_sleep_wake_checker_inst (.core_clk, .rst,
	.clk_en, .avs_read, .avs_write, .avs_waitrequest, .sleep_exec, .pad_out, .pad_oe,
	.device_reset, .osc_drive_en, .asleep, .timeout_flag_n, .powerdown_flag_n, .pin_wake_flag);

// file: tb/swrc_far_pins.sv
`timescale 1ns/100ps
module swrc_far_pins (
	input  wire logic core_clk,
	input  wire logic toggle_ab,
	input  wire logic reset_req,
	output logic      wake_pin_a,
	output logic      wake_pin_b,
	output logic      shared_reset_program_pin
);
	// Pins idle high
	initial begin
		wake_pin_a = 1'b1;
		wake_pin_b = 1'b1;
		shared_reset_program_pin = 1'b1;
	end
	// Pin change and reset pin driven just after the edge
	always @(posedge core_clk) begin
		if (toggle_ab) begin
			{wake_pin_a, wake_pin_b} <= ~{wake_pin_a, wake_pin_b};
		end
		shared_reset_program_pin <= ~reset_req;
	end
endmodule : swrc_far_pins

// file: tb/swrc_sleep_wake_tb.sv
`timescale 1ns/100ps
module swrc_sleep_wake_tb;
	import swrc_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [BE_W-1:0] avs_byteenable = 4'hf;
	logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, got;
	logic sleep_exec = 1'b0, port_access = 1'b0, wdt_clear = 1'b0;
	logic toggle_ab = 1'b0, reset_req = 1'b0;
	logic wake_pin_a, wake_pin_b, shared_reset_program_pin;
	logic [PORT_W-1:0] core_pad_out = '0, core_pad_oe = '0, pad_out, pad_oe;
	logic [2*PORT_W-1:0] pad_exp;
	logic device_reset, osc_drive_en, asleep;
	logic timeout_flag_n, powerdown_flag_n, pin_wake_flag;
	int n_mismatch = 0, checks_done = 0, seed = 32'h8180246c;
	int m_pw = 0, m_to = 1, m_pd = 1, m_sl = 0;
	int ev_q[$];
	localparam int EV_POR = 0, EV_SLEEP = 1, EV_WDT = 2, EV_EXT = 3, EV_CHG = 4;

	swrc_sleep_wake #(.WDT_LIMIT(50)) swrc_sleep_wake_inst (.core_clk, .rst, .clk_en,
		.avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .sleep_exec, .port_access, .wdt_clear, .wake_pin_a, .wake_pin_b,
		.shared_reset_program_pin, .core_pad_out, .core_pad_oe, .pad_out, .pad_oe,
		.device_reset, .osc_drive_en, .asleep, .timeout_flag_n, .powerdown_flag_n,
		.pin_wake_flag);
	swrc_far_pins swrc_far_pins_inst (.core_clk, .toggle_ab, .reset_req, .wake_pin_a,
		.wake_pin_b, .shared_reset_program_pin);

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge core_clk);
		end
		cmp('0, 32'(avs_waitrequest));
		got = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic pulse(input logic [2:0] k);
		{sleep_exec, port_access, wdt_clear} <= k;
		@(posedge core_clk);
		{sleep_exec, port_access, wdt_clear} <= 3'h0;
		@(posedge core_clk);
	endtask : pulse

	task automatic wait_dr(input logic v);
		int n;
		n = 0;
		while (device_reset !== v && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		cmp(32'(v), 32'(device_reset));
		@(posedge core_clk);
	endtask : wait_dr

	// Model: reset-cause flags and sleep state per event
	task automatic model_step(input int ev);
		if (ev == EV_SLEEP) begin
			m_to = 1;
			m_pd = 0;
		end else begin
			if (ev == EV_POR) begin
				m_to = 1;
				m_pd = 1;
			end else if (ev == EV_WDT) begin
				m_to = 0;
				m_pd = m_sl ? 0 : m_pd;
			end else if (m_sl != 0 || ev == EV_CHG) begin
				m_to = 1;
				m_pd = 0;
			end
			m_pw = (ev == EV_CHG) ? 1 : 0;
		end
		m_sl = (ev == EV_SLEEP) ? 1 : 0;
	endtask : model_step

	// Applies queued events, then compares pins and status word
	task automatic chk;
		int e;
		while (ev_q.size() > 0) begin
			model_step(ev_q.pop_front());
		end
		e = (m_pw << STAT_PIN_WAKE_BIT) | (m_to << STAT_TIMEOUT_BIT)
			| (m_pd << STAT_POWERDOWN_BIT) | (m_sl << STAT_ASLEEP_BIT);
		cmp(32'({m_pw[0], m_to[0], m_pd[0], m_sl[0]}),
			32'({pin_wake_flag, timeout_flag_n, powerdown_flag_n, asleep}));
		bus(1'b0, ADDR_STATUS, '0);
		cmp(32'(e), got);
	endtask : chk

	initial begin
		#100000;
		n_mismatch++;
		give_verdict;
	end

	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, ADDR_CONTROL, '0);
		cmp(32'(CTRL_RESET), got);
		bus(1'b0, 4'hc, '0);
		cmp('0, got);
		chk;
		wait_dr(1'b0);
		repeat (4) begin
			repeat (30) @(posedge core_clk);
			pulse(3'h1);
		end
		cmp('0, 32'(device_reset));
		wait_dr(1'b1);
		ev_q.push_back(EV_WDT);
		chk;
		wait_dr(1'b0);
		bus(1'b1, ADDR_CONTROL, 32'h6);
		reset_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset_req <= 1'b0;
		wait_dr(1'b1);
		ev_q.push_back(EV_EXT);
		chk;
		wait_dr(1'b0);
		core_pad_out <= PORT_W'($random(seed));
		core_pad_oe <= PORT_W'($random(seed));
		pulse(3'h2);
		pad_exp = {core_pad_oe, core_pad_out};
		pulse(3'h4);
		ev_q.push_back(EV_SLEEP);
		chk;
		cmp('0, 32'(osc_drive_en));
		{core_pad_oe, core_pad_out} <= ~pad_exp;
		repeat (3) @(posedge core_clk);
		cmp(32'(pad_exp), 32'({pad_oe, pad_out}));
		toggle_ab <= 1'b1;
		@(posedge core_clk);
		toggle_ab <= 1'b0;
		wait_dr(1'b1);
		ev_q.push_back(EV_CHG);
		chk;
		wait_dr(1'b0);
		pulse(3'h4);
		wait_dr(1'b1);
		ev_q.push_back(EV_SLEEP);
		ev_q.push_back(EV_CHG);
		chk;
		wait_dr(1'b0);
		bus(1'b1, ADDR_CONTROL, 32'h3);
		pulse(3'h2);
		bus(1'b0, ADDR_WAKE_REF, '0);
		cmp(32'({shared_reset_program_pin, wake_pin_b, wake_pin_a}), got);
		pulse(3'h4);
		// Frozen watchdog must not wake the block
		clk_en <= 1'b0;
		repeat (80) @(posedge core_clk);
		cmp(32'h1, 32'({device_reset, asleep}));
		clk_en <= 1'b1;
		wait_dr(1'b1);
		ev_q.push_back(EV_SLEEP);
		ev_q.push_back(EV_WDT);
		chk;
		wait_dr(1'b0);
		repeat (35) @(posedge core_clk);
		cmp('0, 32'(device_reset));
		bus(1'b1, ADDR_CONTROL, 32'h4);
		pulse(3'h4);
		reset_req <= 1'b1;
		wait_dr(1'b1);
		ev_q.push_back(EV_SLEEP);
		ev_q.push_back(EV_EXT);
		chk;
		reset_req <= 1'b0;
		wait_dr(1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		ev_q.push_back(EV_POR);
		chk;
		give_verdict;
	end
endmodule : swrc_sleep_wake_tb
